//--- led_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module led_i2c_slave
    import led_i2c_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Two-wire bus pins; the clock line is input only.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select straps.
    input wire logic addr_select_lsb_pin,
    input wire logic addr_select_msb_pin,
    // Register write stream towards the register file.
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data,
    // Register read port, combinational answer from the register file.
    output logic [6:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Status.
    output logic bus_busy
);
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic sel_s1_r, sel_s2_r, sel0_s1_r, sel0_s2_r;
    logic scl_rise, scl_fall, start_det, stop_det;
    slave_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [6:0] ptr_r;
    logic [6:0] sub_r;
    logic cont_r;
    logic busy_r;
    logic rw_r;
    logic ack_phase_r;
    logic drive_low_r;
    logic master_nack_r;
    logic push_r;
    logic [14:0] push_word_r;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [14:0] fifo_out_data;
    logic [6:0] own_addr;

    // Two flops on every pin before any logic looks at it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sel0_s1_r <= 1'b0;
            sel0_s2_r <= 1'b0;
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sel0_s1_r <= addr_select_lsb_pin;
            sel0_s2_r <= sel0_s1_r;
            sel_s1_r <= addr_select_msb_pin;
            sel_s2_r <= sel_s1_r;
        end
    end

    // Delayed copies for edge detection on the synchronised lines.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s2_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // Clock edges are found by sampling; 50 core cycles per fast bit.
    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    assign start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    assign stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
    assign own_addr = TARGET_ADDR_BASE | {5'h00, sel_s2_r, sel0_s2_r};

    // Busy from START until STOP; a repeated START keeps it set.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end
    assign bus_busy = busy_r;

    // Main byte engine; data is taken on rising clock edges, MSB first.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 7'h00;
            sub_r <= 7'h00;
            cont_r <= 1'b0;
            rw_r <= 1'b0;
            ack_phase_r <= 1'b0;
            drive_low_r <= 1'b0;
            master_nack_r <= 1'b0;
            push_r <= 1'b0;
            push_word_r <= 15'h0000;
        end else begin
            if (push_r && fifo_in_ready) begin
                push_r <= 1'b0;
            end
            if (start_det) begin
                // The master frames every transfer; restart the bit count.
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                ack_phase_r <= 1'b0;
                drive_low_r <= 1'b0;
                master_nack_r <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                drive_low_r <= 1'b0;
            end else if (state_r != ST_IDLE && scl_rise) begin
                if (!ack_phase_r) begin
                    shift_r <= {shift_r[6:0], sda_s2_r};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else if (rw_r && state_r == ST_RDATA) begin
                    // Master acknowledge sampled on the ninth clock.
                    master_nack_r <= sda_s2_r;
                end
            end else if (state_r != ST_IDLE && scl_fall) begin
                if (!ack_phase_r && bit_cnt_r == 4'(BYTE_BITS)) begin
                    ack_phase_r <= 1'b1;
                    bit_cnt_r <= 4'h0;
                    drive_low_r <= 1'b0;
                    case (state_r)
                        ST_ADDR: begin
                            rw_r <= shift_r[0];
                            if (shift_r[7:1] == own_addr) begin
                                drive_low_r <= 1'b1;
                                // A bare read restarts at the last written
                                // sub-address, not where a burst ended.
                                if (shift_r[0]) begin
                                    ptr_r <= sub_r;
                                end
                            end else begin
                                state_r <= ST_IDLE;
                                ack_phase_r <= 1'b0;
                            end
                        end
                        ST_SUB: begin
                            cont_r <= shift_r[SUB_CONT_BIT];
                            ptr_r <= shift_r[6:0];
                            sub_r <= shift_r[6:0];
                            drive_low_r <= 1'b1;
                        end
                        ST_WDATA: begin
                            push_r <= 1'b1;
                            push_word_r <= {ptr_r, shift_r};
                            if (cont_r) begin
                                ptr_r <= ptr_r + 7'h01;
                            end
                            drive_low_r <= 1'b1;
                        end
                        ST_RDATA: begin
                            if (cont_r) begin
                                ptr_r <= ptr_r + 7'h01;
                            end
                        end
                        default: begin
                            state_r <= ST_IDLE;
                        end
                    endcase
                end else if (ack_phase_r) begin
                    // Ninth clock over: decide the next byte.
                    ack_phase_r <= 1'b0;
                    drive_low_r <= 1'b0;
                    case (state_r)
                        ST_ADDR: begin
                            if (rw_r) begin
                                // Bare read uses stored pointer and mode.
                                state_r <= ST_RDATA;
                                tx_r <= rd_data;
                                drive_low_r <= ~rd_data[7];
                            end else begin
                                state_r <= ST_SUB;
                            end
                        end
                        ST_SUB: begin
                            state_r <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            state_r <= ST_WDATA;
                        end
                        ST_RDATA: begin
                            if (master_nack_r) begin
                                state_r <= ST_IDLE;
                            end else begin
                                tx_r <= rd_data;
                                drive_low_r <= ~rd_data[7];
                            end
                        end
                        default: begin
                            state_r <= ST_IDLE;
                        end
                    endcase
                end else if (state_r == ST_RDATA) begin
                    // Next data bit, most significant first.
                    tx_r <= {tx_r[6:0], 1'b0};
                    drive_low_r <= ~tx_r[6];
                end
            end
        end
    end

    // Writes queue towards the register file; a full queue stretches
    // nothing on the bus, so the register file must drain faster than
    // one byte per nine bus clocks.
    led_i2c_fifo #(
        .WIDTH(15),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(push_word_r),
        .out_valid(fifo_out_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out_data)
    );
    assign wr_valid = fifo_out_valid;
    assign wr_addr = fifo_out_data[14:8];
    assign wr_data = fifo_out_data[7:0];
    assign rd_addr = ptr_r;

    // Open drain: only ever pull the data line low; clock never driven.
    assign sda_out = 1'b0;
    assign sda_oe = drive_low_r;
endmodule // led_i2c_slave
`default_nettype wire

//--- led_i2c_pkg.sv
// Functional notes
// - Works at standard 100 kbps and fast 400 kbps; no high-speed mode.
// - Acts only as target; never drives clock or starts transactions.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high.
// - Bus is busy from START until STOP, free only after STOP.
// - Each byte is eight bits; any number of bytes per transaction.
// - An acknowledge bit on the ninth clock follows every byte.
// - Bits move most significant first in both directions.
// - Address is 0110000 plus two select pins in the low bits.
// - Read without sub-address returns register at last written pointer.
// - Sub-address top bit selects continuous mode; low seven bits start.
// - Stored continuous flag makes a later bare read run continuously.
package led_i2c_pkg;
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h30;
    localparam int CORE_CLK_HZ = 20000000;
    localparam int FAST_RATE_BPS = 400000;
    // Core cycles per fast bit; must stay well above 8 for edge sampling.
    localparam int CYCLES_PER_BIT = CORE_CLK_HZ / FAST_RATE_BPS;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_BIT_NUM = 4'h8;
    localparam int SUB_CONT_BIT = 7;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_SUB = 5'h04,
        ST_WDATA = 5'h08,
        ST_RDATA = 5'h10
    } slave_state_t;
endpackage

//--- led_i2c_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module led_i2c_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Honest flags come straight from the fill count.
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];

    // Storage has no reset; only words that were pushed are ever read.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // led_i2c_fifo
`default_nettype wire

//--- led_i2c_slave_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module led_i2c_slave_monitor (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Write stream and status.
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic bus_busy
);
    // All checks share the core clock and its reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_od; sda_out == 1'h0; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_start; $fell(sda_in) && scl_in && $past(scl_in)
        |-> ##[1:8] bus_busy; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_stop; $rose(sda_in) && scl_in && $past(scl_in)
        |-> ##[1:8] !bus_busy; endproperty
    a_stop: assert property (p_stop) else $error("stop missed");
    property p_free; $fell(bus_busy) |-> sda_in && scl_in; endproperty
    a_free: assert property (p_free) else $error("freed early");
    // Changing data with the clock high would fake a start or stop.
    property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
    a_edge: assert property (p_edge) else $error("data moved high");
    property p_quiet; !bus_busy |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("drive when idle");
    property p_hold; wr_valid && !wr_ready
        |=> wr_valid && $stable(wr_addr) && $stable(wr_data); endproperty
    a_hold: assert property (p_hold) else $error("word not held");
    property p_pop; $fell(wr_valid) |-> $past(wr_ready); endproperty
    a_pop: assert property (p_pop) else $error("word dropped");
endmodule // led_i2c_slave_monitor
bind led_i2c_slave led_i2c_slave_monitor i_mon (.core_clk(core_clk),
    .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .bus_busy(bus_busy));
`default_nettype wire

//--- led_i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_i2c_master_model (
    // Data line as seen after the pull-up.
    input wire logic sda_line,
    // Driven lines; a high data drive releases the line.
    output logic scl,
    output logic sda_drv
);
    // Idle bus: both lines released, clock stands still.
    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end
    // Waits out the target's drive, then data falls with clock high.
    task automatic start();
        #250 sda_drv = 1'h1;
        #100 scl = 1'h1;
        #200 sda_drv = 1'h0;
        #300 scl = 1'h0;
    endtask
    // Data rises with clock high; the bus then stays free a while.
    task automatic stop();
        #250 sda_drv = 1'h0;
        #100 scl = 1'h1;
        #200 sda_drv = 1'h1;
        #400;
    endtask
    // One 400 ns bit; low phase is long enough for the target to answer.
    task automatic bit1(input logic b, output logic s);
        #100 sda_drv = b;
        #150 scl = 1'h1;
        #100 s = sda_line;
        #50 scl = 1'h0;
    endtask
    // Eight bits MSB first, then the acknowledge slot.
    task automatic xbyte(input logic [7:0] d, input logic ai,
                         output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
        bit1(ai, ao);
    endtask
endmodule // led_i2c_master_model
`default_nettype wire

//--- led_i2c_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module led_i2c_slave_tb;
    import led_i2c_pkg::*;
    logic core_clk, rst_n, scl, sda_drv, sda_oe, sda_out, ack;
    logic sel_lsb, sel_msb, wr_valid, wr_ready, bus_busy;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data, q;
    logic [7:0] regs [0:127];
    logic [6:0] base;
    int n_mismatch, checks;
    // Open-drain data line with pull-up.
    wire sda_line = sda_drv & !sda_oe;
    assign base = TARGET_ADDR_BASE;
    // Register file stand-in takes words on the handshake.
    always @(posedge core_clk) begin
        if (wr_valid && wr_ready) regs[wr_addr] <= wr_data;
    end
    // Core clock.
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    led_i2c_slave i_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_lsb_pin(sel_lsb), .addr_select_msb_pin(sel_msb),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(regs[rd_addr]),
        .bus_busy(bus_busy));
    led_i2c_master_model i_m (.sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Sends a byte and compares the acknowledge slot.
    task automatic wb(input logic [7:0] b, input logic ea);
        i_m.xbyte(b, 1'h1, q, ack);
        chk({7'h0, ack}, {7'h0, ea});
    endtask
    task automatic rb(input logic [7:0] e, input logic nack);
        i_m.xbyte(8'hFF, nack, q, ack);
        chk(q, e);
    endtask
    // Bounded wait for the write stream to empty.
    task automatic drain();
        int i;
        for (i = 0; i < 200 && wr_valid !== 1'h0; i++) @(negedge core_clk);
        if (i == 200) begin
            chk(8'h01, 8'h00);
            summarize();
        end
    endtask
    task automatic t_single();
        i_m.start();
        wb({base, 1'h0}, 1'h0);
        chk({7'h0, bus_busy}, 8'h01);
        wb(8'h06, 1'h0);
        wb(8'h11, 1'h0);
        wb(8'h22, 1'h0);
        i_m.stop();
        drain();
        chk({7'h0, bus_busy}, 8'h00);
        chk(regs[6], 8'h22);
        chk(regs[7], 8'h00);
    endtask
    // Burst into a stalled stream; nothing may be lost.
    task automatic t_burst();
        wr_ready = 1'h0;
        i_m.start();
        wb({base, 1'h0}, 1'h0);
        wb(8'h90, 1'h0);
        for (int k = 0; k < 4; k++) wb(8'hA0 + 8'(k), 1'h0);
        i_m.stop();
        chk({7'h0, wr_valid}, 8'h01);
        @(negedge core_clk);
        wr_ready = 1'h1;
        drain();
        for (int k = 0; k < 4; k++) chk(regs[16 + k], 8'hA0 + 8'(k));
    endtask
    task automatic t_bare();
        i_m.start();
        wb({base, 1'h1}, 1'h0);
        rb(8'hA0, 1'h0);
        rb(8'hA1, 1'h0);
        rb(8'hA2, 1'h1);
        #250;
        chk({7'h0, sda_oe}, 8'h00);
        i_m.stop();
    endtask
    task automatic t_sub();
        i_m.start();
        wb({base, 1'h0}, 1'h0);
        wb(8'h06, 1'h0);
        i_m.start();
        wb({base, 1'h1}, 1'h0);
        rb(8'h22, 1'h0);
        rb(8'h22, 1'h1);
        i_m.stop();
    endtask
    // Every strap setting: own address answered, a neighbour ignored.
    task automatic t_addr();
        for (int s = 0; s < 4; s++) begin
            {sel_msb, sel_lsb} = 2'(s);
            repeat (4) @(negedge core_clk);
            i_m.start();
            wb({base[6:2], 2'(s + 1), 1'h0}, 1'h1);
            i_m.stop();
            i_m.start();
            wb({base[6:2], 2'(s), 1'h0}, 1'h0);
            i_m.stop();
        end
    endtask
    initial begin
        rst_n = 1'h0;
        wr_ready = 1'h1;
        {sel_msb, sel_lsb} = 2'h0;
        n_mismatch = 0;
        checks = 0;
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (12) @(negedge core_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge core_clk);
        t_single();
        t_burst();
        t_bare();
        t_sub();
        t_addr();
        summarize();
    end
endmodule // led_i2c_slave_tb
`default_nettype wire
